// ---- rtl/ovt_overlay_map_event_trace.sv ----
// Purpose: overlay mapper, event monitor, trace buffer and aux pod logic
// Assumes: pod processor bus on the same clock, aux pod pins asynchronous
// Notes: overlay is indexed by low address bits and mirrors above its size
// Functional notes
// - address space split into 2KB map units
// - each unit: target, rw, read-only, illegal
// - overlay-mapped accesses served from overlay memory
// - illegal or read-only write halts emulation
// - zero to fifteen wait states on overlay
// - no added delay within variant speed limit
// - trace keeps last 2046 bus cycles
// - entry holds address, data, status, aux bits
// - aux pod: 16 inputs, one trigger output
// - aux bit pattern can cause a break
// - events combine address, data, status, counter, aux
// - actions: break, trace qualify, count, trigger
// - four event groups with group jumps
// - action forces special shutdown interrupt
// - operator stop halts emulation any time
// - dynamic trace readable while running
// - internal clock, target units from overlay
`timescale 1ns/1ps
module ovt_overlay_map_event_trace
	import ovt_pkg::*;
#(
	parameter int FAST_OVL = 0, // high-speed overlay variant
	parameter int CPU_MHZ = 10, // processor clock rate
	parameter int OVL_AW = 14, // overlay words, log2
	parameter int TRC_DEPTH = TRACE_DEPTH,
	parameter int DYN_TRACE = 1, // dynamic trace option fitted
	parameter int INT_CLK_HALF = 2 // internal clock half period
)(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output logic irq,
	input wire logic cpuReq,
	input wire logic [ADDR_W-1:0] cpuAddr,
	input wire logic cpuWr,
	input wire logic [DATA_W-1:0] cpuWdata,
	input wire logic [STAT_W-1:0] cpuStat,
	output logic [DATA_W-1:0] cpuRdata,
	output logic cpuReady,
	output logic cpuHold,
	output logic cpuSpecInt,
	output logic tgtReq,
	output logic [ADDR_W-1:0] tgtAddr,
	output logic tgtWr,
	output logic [DATA_W-1:0] tgtWdata,
	input wire logic [DATA_W-1:0] tgtRdata,
	input wire logic tgtReady,
	input wire logic [AUX_W-1:0] auxPodIn,
	output logic auxTrigOut,
	output logic intClk,
	output logic intClkSel
);
	// the standard board needs one extra wait above its rated speed
	localparam logic [WS_W:0] WS_EXTRA = (FAST_OVL == 0 && CPU_MHZ > STD_MAX_MHZ) ?
		(WS_W+1)'(1) : '0;
	localparam logic [TRACE_AW:0] TRC_MAX = (TRACE_AW+1)'(TRC_DEPTH);
	typedef enum logic [1:0] {BS_IDLE, BS_OVL, BS_TGT, BS_DONE} ovt_bus_e;

	// masked compare, shared by the address, data, status and aux fields
	function automatic logic matchBits(input logic [31:0] x, input logic [31:0] v,
		input logic [31:0] m);
		return ((x ^ v) & m) == '0;
	endfunction

	// fold a trace index back into the ring
	function automatic logic [TRACE_AW-1:0] wrapIdx(input logic [TRACE_AW:0] s);
		logic [TRACE_AW:0] t;
		t = (s >= TRC_MAX) ? s - TRC_MAX : s;
		return t[TRACE_AW-1:0];
	endfunction

	// aux pod synchroniser and settled value
	logic [AUX_W-1:0] auxS1_r, auxS2_r, auxS3_r, aux_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			auxS1_r <= '0;
			auxS2_r <= '0;
			auxS3_r <= '0;
			aux_r <= '0;
		end else begin
			auxS1_r <= auxPodIn;
			auxS2_r <= auxS1_r;
			auxS3_r <= auxS2_r;
			if (auxS2_r == auxS3_r) aux_r <= auxS3_r;
		end
	end

	// register write decode
	wire wrCtrl = regWr && regAddr == REG_CTRL;
	wire wrIstat = regWr && regAddr == REG_ISTAT;
	wire wrImask = regWr && regAddr == REG_IMASK;
	wire wrMapIdx = regWr && regAddr == REG_MAPIDX;
	wire wrMapAttr = regWr && regAddr == REG_MAPATTR;
	wire wrEvSel = regWr && regAddr == REG_EVSEL;
	wire wrEvAddr = regWr && regAddr == REG_EVADDR;
	wire wrEvAmsk = regWr && regAddr == REG_EVAMSK;
	wire wrEvData = regWr && regAddr == REG_EVDATA;
	wire wrEvAux = regWr && regAddr == REG_EVAUX;
	wire wrEvStat = regWr && regAddr == REG_EVSTAT;
	wire wrEvAct = regWr && regAddr == REG_EVACT;
	wire wrCntLim = regWr && regAddr == REG_CNTLIM;
	wire wrTrIdx = regWr && regAddr == REG_TRIDX;
	wire wrOvlAdr = regWr && regAddr == REG_OVLADR;
	wire wrOvlDat = regWr && regAddr == REG_OVLDAT;
	wire rdTrHi = regRd && regAddr == REG_TRHI; // read steps the index

	// control and event state
	logic running_r, nullTarget_r, specInt_r, traceOn_r, trig_r;
	logic [WS_W-1:0] waitStates_r;
	logic [IRQ_W-1:0] istat_r, imask_r;
	logic [SEG_IW-1:0] mapIdx_r;
	logic [GRP_W-1:0] evSel_r, curGrp_r;
	logic [CNT_W-1:0] evCount_r, cntLim_r;
	logic [TRACE_AW-1:0] trIdx_r, trWrPtr_r;
	logic [TRACE_AW:0] trCount_r;
	logic [OVL_AW-1:0] ovlAdr_r;
	ovt_attr_e segMap [NUM_SEG]; // one attribute per unit
	ovt_evc_s evCond [NUM_GRP];
	ovt_act_s evAct [NUM_GRP];
	logic [DATA_W-1:0] ovlMem [2**OVL_AW];
	logic [CYC_W-1:0] trMem [TRC_DEPTH];

	// bus cycle state
	ovt_bus_e bsState_r;
	ovt_cyc_s cyc_r;
	logic cycViol_r;
	logic [WS_W:0] waitCnt_r;

	// map lookup for the access on offer
	wire [SEG_IW-1:0] segIdx = cpuAddr[ADDR_W-1:SEG_BITS];
	ovt_attr_e attr;
	assign attr = segMap[segIdx];
	wire accept = bsState_r == BS_IDLE && cpuReq && running_r;
	wire viol = attr == ATTR_ILLEGAL || (attr == ATTR_RO && cpuWr);
	// null target turns target units into overlay
	wire toOvl = attr == ATTR_RW || attr == ATTR_RO || nullTarget_r;
	wire [WS_W:0] wsEff = (WS_W+1)'(waitStates_r) + WS_EXTRA;
	wire ovlEnd = bsState_r == BS_OVL && waitCnt_r == wsEff;
	wire tgtEnd = bsState_r == BS_TGT && tgtReady;
	wire cycDone = bsState_r == BS_DONE;

	// event evaluation on the finished cycle
	ovt_evc_s ec;
	ovt_act_s ea;
	assign ec = evCond[curGrp_r];
	assign ea = evAct[curGrp_r];
	wire auxHit = matchBits(32'(cyc_r.aux), 32'(ec.auxVal), 32'(ec.auxMsk));
	wire cntOk = !ec.useCnt || evCount_r >= cntLim_r;
	wire evHit = cycDone && running_r && cntOk && auxHit &&
		matchBits(32'(cyc_r.addr), 32'(ec.addrVal), 32'(ec.addrMsk)) &&
		matchBits(32'(cyc_r.data), 32'(ec.dataVal), 32'(ec.dataMsk)) &&
		matchBits(32'(cyc_r.stat), 32'(ec.statVal), 32'(ec.statMsk));
	wire brkHit = evHit && ea.brk;
	wire trigHit = evHit && ea.trig;
	wire violHalt = cycDone && cycViol_r && running_r;
	wire runNow = wrCtrl && regWdata[CTRL_RUN];
	wire stopNow = wrCtrl && regWdata[CTRL_STOP];
	wire haltNow = stopNow || brkHit || violHalt;
	wire running_nxt = haltNow ? 1'b0 : (runNow ? 1'b1 : running_r);
	wire trRec = cycDone && running_r && traceOn_r;
	wire [IRQ_W-1:0] irqSet = {trigHit, brkHit, violHalt, running_r && !running_nxt};
	wire [IRQ_W-1:0] irqClr = wrIstat ? regWdata[IRQ_W-1:0] : '0;
	// set wins over a same-cycle clear
	wire [IRQ_W-1:0] istat_nxt = (istat_r & ~irqClr) | irqSet;

	// control, interrupt and event registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			running_r <= 1'b0;
			nullTarget_r <= 1'b0;
			waitStates_r <= '0;
			istat_r <= '0;
			imask_r <= '0;
			specInt_r <= 1'b0;
			traceOn_r <= 1'b1;
			trig_r <= 1'b0;
			curGrp_r <= '0;
			evCount_r <= '0;
		end else begin
			running_r <= running_nxt;
			istat_r <= istat_nxt;
			trig_r <= trigHit;
			if (wrCtrl) nullTarget_r <= regWdata[CTRL_NULL];
			if (wrCtrl) waitStates_r <= regWdata[CTRL_WS_LO +: WS_W];
			if (wrImask) imask_r <= regWdata[IRQ_W-1:0];
			// special interrupt stays up until the program is halted or run again
			if (haltNow || runNow) specInt_r <= 1'b0;
			else if (evHit && ea.sint) specInt_r <= 1'b1;
			if (evHit && ea.trcOn) traceOn_r <= 1'b1;
			else if (evHit && ea.trcOff) traceOn_r <= 1'b0;
			if (runNow) curGrp_r <= '0;
			else if (evHit && ea.jump) curGrp_r <= ea.next;
			if (runNow) evCount_r <= '0;
			else if (evHit && ea.cnt) evCount_r <= evCount_r + 1'b1;
		end
	end

	// software-written tables and pointers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mapIdx_r <= '0;
			evSel_r <= '0;
			cntLim_r <= '0;
			ovlAdr_r <= '0;
			for (int i = 0; i < NUM_SEG; i++) segMap[i] <= ATTR_TARGET;
			for (int g = 0; g < NUM_GRP; g++) begin
				evCond[g] <= '0;
				evAct[g] <= '0;
			end
		end else begin
			if (wrMapIdx) mapIdx_r <= regWdata[SEG_IW-1:0];
			if (wrMapAttr) segMap[mapIdx_r] <= ovt_attr_e'(regWdata[1:0]);
			if (wrEvSel) evSel_r <= regWdata[GRP_W-1:0];
			if (wrCntLim) cntLim_r <= regWdata[CNT_W-1:0];
			if (wrOvlAdr) ovlAdr_r <= regWdata[OVL_AW-1:0];
			if (wrEvAddr) evCond[evSel_r].addrVal <= regWdata[ADDR_W-1:0];
			if (wrEvAmsk) evCond[evSel_r].addrMsk <= regWdata[ADDR_W-1:0];
			if (wrEvData) evCond[evSel_r].dataVal <= regWdata[DATA_W-1:0];
			if (wrEvData) evCond[evSel_r].dataMsk <= regWdata[HALF_LO +: DATA_W];
			if (wrEvAux) evCond[evSel_r].auxVal <= regWdata[AUX_W-1:0];
			if (wrEvAux) evCond[evSel_r].auxMsk <= regWdata[HALF_LO +: AUX_W];
			if (wrEvStat) evCond[evSel_r].statVal <= regWdata[STAT_W-1:0];
			if (wrEvStat) evCond[evSel_r].statMsk <= regWdata[EVS_MSK_LO +: STAT_W];
			if (wrEvStat) evCond[evSel_r].useCnt <= regWdata[EVS_CNT];
			if (wrEvAct) evAct[evSel_r] <= ovt_act_s'(regWdata[ACT_W-1:0]);
		end
	end

	// bus cycle sequencer: overlay, target or violation
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bsState_r <= BS_IDLE;
			cyc_r <= '0;
			cycViol_r <= 1'b0;
			waitCnt_r <= '0;
		end else begin
			case (bsState_r)
				BS_IDLE: begin
					waitCnt_r <= '0;
					if (accept) begin
						// capture the whole cycle; a refused read carries zero, not the write lines
						cyc_r <= '{cpuAddr, (viol && !cpuWr) ? '0 : cpuWdata, cpuStat, cpuWr, aux_r};
						cycViol_r <= viol;
						// a violation is finished locally, never forwarded
						if (viol) bsState_r <= BS_DONE;
						else if (toOvl) bsState_r <= BS_OVL;
						else bsState_r <= BS_TGT;
					end
				end
				BS_OVL: begin
					waitCnt_r <= waitCnt_r + 1'b1;
					if (ovlEnd) begin
						if (!cyc_r.wr) cyc_r.data <= ovlMem[cyc_r.addr[OVL_AW-1:0]];
						bsState_r <= BS_DONE;
					end
				end
				BS_TGT: begin
					if (tgtEnd) begin
						if (!cyc_r.wr) cyc_r.data <= tgtRdata;
						bsState_r <= BS_DONE;
					end
				end
				BS_DONE: begin
					if (cycViol_r && !cyc_r.wr) cyc_r.data <= '0;
					cycViol_r <= 1'b0;
					bsState_r <= BS_IDLE;
				end
				default: bsState_r <= BS_IDLE;
			endcase
		end
	end

	// overlay memory, processor write takes the port before software
	always_ff @(posedge clock) begin
		if (ovlEnd && cyc_r.wr) ovlMem[cyc_r.addr[OVL_AW-1:0]] <= cyc_r.data;
		else if (wrOvlDat) ovlMem[ovlAdr_r] <= regWdata[DATA_W-1:0];
	end

	// trace ring: overwrite oldest, stop writing once halted
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			trWrPtr_r <= '0;
			trCount_r <= '0;
			trIdx_r <= '0;
		end else begin
			if (trRec) trWrPtr_r <= wrapIdx(trWrPtr_r + 1'b1);
			if (trRec && trCount_r != TRC_MAX) trCount_r <= trCount_r + 1'b1;
			if (wrTrIdx) trIdx_r <= regWdata[TRACE_AW-1:0];
			else if (rdTrHi) trIdx_r <= wrapIdx(trIdx_r + 1'b1);
		end
	end
	always_ff @(posedge clock) begin
		if (trRec) trMem[trWrPtr_r] <= cyc_r;
	end

	// trace read, index zero is the oldest entry kept
	wire [TRACE_AW-1:0] trOld = (trCount_r == TRC_MAX) ? trWrPtr_r : '0;
	wire [TRACE_AW-1:0] trRdPtr = wrapIdx(trOld + trIdx_r);
	wire trBlock = DYN_TRACE == 0 && running_r;
	wire [CYC_W-1:0] trEntry = trBlock ? '0 : trMem[trRdPtr];

	// read selection
	logic [31:0] rdMux;
	always_comb begin
		case (regAddr)
			REG_CTRL: rdMux = (32'(waitStates_r) << CTRL_WS_LO) | (32'(nullTarget_r) << CTRL_NULL);
			REG_STAT: rdMux = (32'(evCount_r) << HALF_LO) | (32'(specInt_r) << STS_SINT) |
				(32'(curGrp_r) << STS_GRP_LO) | 32'(running_r);
			REG_ISTAT: rdMux = 32'(istat_r);
			REG_IMASK: rdMux = 32'(imask_r);
			REG_MAPIDX: rdMux = 32'(mapIdx_r);
			REG_MAPATTR: rdMux = 32'(segMap[mapIdx_r]);
			REG_EVSEL: rdMux = 32'(evSel_r);
			REG_EVADDR: rdMux = 32'(evCond[evSel_r].addrVal);
			REG_EVAMSK: rdMux = 32'(evCond[evSel_r].addrMsk);
			REG_EVDATA: rdMux = {evCond[evSel_r].dataMsk, evCond[evSel_r].dataVal};
			REG_EVAUX: rdMux = {evCond[evSel_r].auxMsk, evCond[evSel_r].auxVal};
			REG_EVSTAT: rdMux = (32'(evCond[evSel_r].useCnt) << EVS_CNT) |
				(32'(evCond[evSel_r].statMsk) << EVS_MSK_LO) | 32'(evCond[evSel_r].statVal);
			REG_EVACT: rdMux = 32'(evAct[evSel_r]);
			REG_CNTLIM: rdMux = 32'(cntLim_r);
			REG_TRIDX: rdMux = 32'(trIdx_r);
			REG_TRLO: rdMux = trEntry[31:0];
			REG_TRHI: rdMux = 32'(trEntry[CYC_W-1:32]);
			REG_TRCNT: rdMux = 32'(trCount_r);
			REG_OVLADR: rdMux = 32'(ovlAdr_r);
			REG_OVLDAT: rdMux = 32'(ovlMem[ovlAdr_r]);
			default: rdMux = '0; // unmapped reads zero
		endcase
	end

	// read data for one cycle only; internal clock divider
	logic [31:0] regRdata_r;
	logic intClk_r;
	logic [7:0] intClkCnt_r;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			regRdata_r <= '0;
			intClk_r <= 1'b0;
			intClkCnt_r <= '0;
		end else begin
			regRdata_r <= regRd ? rdMux : '0;
			if (!nullTarget_r) intClkCnt_r <= '0;
			else if (intClkCnt_r == 8'(INT_CLK_HALF - 1)) intClkCnt_r <= '0;
			else intClkCnt_r <= intClkCnt_r + 1'b1;
			if (nullTarget_r && intClkCnt_r == 8'(INT_CLK_HALF - 1)) intClk_r <= !intClk_r;
		end
	end

	assign regRdata = regRdata_r;
	assign irq = |(istat_r & imask_r);
	assign cpuRdata = cyc_r.data;
	assign cpuReady = cycDone;
	assign cpuHold = !running_r;
	assign cpuSpecInt = specInt_r;
	assign tgtReq = bsState_r == BS_TGT;
	assign tgtAddr = cyc_r.addr;
	assign tgtWr = cyc_r.wr;
	assign tgtWdata = cyc_r.data;
	assign auxTrigOut = trig_r;
	assign intClk = intClk_r;
	assign intClkSel = nullTarget_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence sOvlAcc;
		accept && !viol && toOvl;
	endsequence
	sequence sTrigPulse;
		auxTrigOut ##1 !auxTrigOut;
	endsequence
	AST_VIOL_HALT: assert property (violHalt |=> !running_r)
		else $error("violation did not halt");
	AST_OVL_NO_TGT: assert property (sOvlAcc |=> !tgtReq [*2])
		else $error("overlay access reached target");
	AST_OVL_WAITS: assert property (sOvlAcc ##1 (waitCnt_r == wsEff) |=> cpuReady)
		else $error("overlay wait count wrong");
	AST_TRC_FULL: assert property (trCount_r <= TRC_MAX)
		else $error("trace count over depth");
	AST_TRC_FREEZE: assert property (!running_r |=> $stable(trWrPtr_r))
		else $error("trace moved while halted");
	AST_BRK: assert property (brkHit |=> !running_r && cpuHold)
		else $error("break action missed");
	AST_TRIG: assert property (trigHit && !$past(trigHit) |=> sTrigPulse)
		else $error("trigger output not one pulse");
	AST_STOP: assert property (stopNow |=> !running_r)
		else $error("stop request ignored");
	AST_NULL_TGT: assert property (accept && nullTarget_r |=> !tgtReq)
		else $error("null target sent to target");
	AST_SINT: assert property (evHit && ea.sint && !haltNow && !runNow |=> cpuSpecInt)
		else $error("special interrupt missed");
	AST_JUMP: assert property (evHit && ea.jump && !runNow |=> curGrp_r == $past(ea.next))
		else $error("group jump wrong");
endmodule

// ---- rtl/ovt_pkg.sv ----
// Purpose: constants and carriers for the overlay map, event and trace block
// Assumes: 32-bit register port, byte offsets, one clock
// Notes: attribute order gives the stored two-bit code
package ovt_pkg;
	localparam int ADDR_W = 20; // processor address
	localparam int DATA_W = 16;
	localparam int STAT_W = 3; // bus status lines
	localparam int AUX_W = 16; // aux pod inputs
	localparam int SEG_BITS = 11; // 2KB mapping unit
	localparam int SEG_IW = ADDR_W - SEG_BITS;
	localparam int NUM_SEG = 2 ** SEG_IW;
	localparam int NUM_GRP = 4; // event groups
	localparam int GRP_W = 2;
	localparam int TRACE_DEPTH = 2046;
	localparam int TRACE_AW = 11;
	localparam int WS_W = 4; // 0..15 wait states
	localparam int STD_MAX_MHZ = 12;
	localparam int FAST_MAX_MHZ = 16;
	localparam int CNT_W = 16;
	localparam int IRQ_W = 4;
	localparam int HALF_LO = 16; // upper half of a word
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_ISTAT = 8'h08;
	localparam logic [7:0] REG_IMASK = 8'h0c;
	localparam logic [7:0] REG_MAPIDX = 8'h10;
	localparam logic [7:0] REG_MAPATTR = 8'h14;
	localparam logic [7:0] REG_EVSEL = 8'h18;
	localparam logic [7:0] REG_EVADDR = 8'h1c;
	localparam logic [7:0] REG_EVAMSK = 8'h20;
	localparam logic [7:0] REG_EVDATA = 8'h24;
	localparam logic [7:0] REG_EVAUX = 8'h28;
	localparam logic [7:0] REG_EVSTAT = 8'h2c;
	localparam logic [7:0] REG_EVACT = 8'h30;
	localparam logic [7:0] REG_CNTLIM = 8'h34;
	localparam logic [7:0] REG_TRIDX = 8'h38;
	localparam logic [7:0] REG_TRLO = 8'h3c;
	localparam logic [7:0] REG_TRHI = 8'h40;
	localparam logic [7:0] REG_TRCNT = 8'h44;
	localparam logic [7:0] REG_OVLADR = 8'h48;
	localparam logic [7:0] REG_OVLDAT = 8'h4c;
	// field positions
	localparam int CTRL_RUN = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_NULL = 2;
	localparam int CTRL_WS_LO = 4;
	localparam int STS_GRP_LO = 1;
	localparam int STS_SINT = 3;
	localparam int EVS_MSK_LO = 4;
	localparam int EVS_CNT = 8;
	localparam int IRQ_HALT = 0;
	localparam int IRQ_VIOL = 1;
	localparam int IRQ_BRK = 2;
	localparam int IRQ_TRIG = 3;
	typedef enum logic [1:0] {ATTR_TARGET, ATTR_RW, ATTR_RO, ATTR_ILLEGAL} ovt_attr_e;
	// one traced bus cycle
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [STAT_W-1:0] stat;
		logic wr;
		logic [AUX_W-1:0] aux;
	} ovt_cyc_s;
	localparam int CYC_W = $bits(ovt_cyc_s);
	// event comparison, mask bit one means compare
	typedef struct packed {
		logic [ADDR_W-1:0] addrVal;
		logic [ADDR_W-1:0] addrMsk;
		logic [DATA_W-1:0] dataVal;
		logic [DATA_W-1:0] dataMsk;
		logic [AUX_W-1:0] auxVal;
		logic [AUX_W-1:0] auxMsk;
		logic useCnt;
		logic [STAT_W-1:0] statMsk;
		logic [STAT_W-1:0] statVal;
	} ovt_evc_s;
	typedef struct packed {
		logic brk;
		logic trcOn;
		logic trcOff;
		logic cnt;
		logic trig;
		logic sint;
		logic jump;
		logic [GRP_W-1:0] next;
	} ovt_act_s;
	localparam int ACT_W = $bits(ovt_act_s);
endpackage

// ---- dv/ovt_tgt_model.sv ----
// Purpose: target system bus model answering cycles forwarded by the mapper
// Assumes: same clock as the block, answer delay set by the bench
// Notes: data lines carry toggling junk whenever no answer is on them
`timescale 1ns/1ps
module ovt_tgt_model
	import ovt_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic tgtReq,
	input wire logic [ADDR_W-1:0] tgtAddr,
	input wire logic tgtWr,
	input wire logic [DATA_W-1:0] tgtWdata,
	input wire logic [3:0] waitCnt,
	output logic [DATA_W-1:0] tgtRdata,
	output logic tgtReady
);
	logic [DATA_W-1:0] mem [0:255]; // small word memory, upper address ignored
	logic [3:0] cnt_r; // cycles spent on the open request
	// answer one cycle, after waitCnt cycles; a slow answer tests the wait path
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= 4'h0;
			tgtReady <= 1'b0;
			tgtRdata <= 16'h0;
		end else if (tgtReq && !tgtReady && cnt_r == waitCnt) begin
			tgtReady <= 1'b1;
			cnt_r <= 4'h0;
			if (tgtWr) begin
				mem[tgtAddr[8:1]] <= tgtWdata;
			end
			// writes leave the bus undriven, so show the inverse
			tgtRdata <= tgtWr ? ~tgtWdata : mem[tgtAddr[8:1]];
		end else begin
			tgtReady <= 1'b0;
			cnt_r <= (tgtReq && !tgtReady) ? cnt_r + 4'h1 : 4'h0;
			tgtRdata <= ~tgtRdata; // released bus never holds the last word
		end
	end
endmodule

// ---- dv/ovt_overlay_map_event_trace_tb_top.sv ----
// Purpose: register and processor bus tests of the overlay, event and trace block
// Assumes: standard overlay board at 10 MHz, dynamic trace fitted
// Notes: latencies are checked as differences, so fixed pipeline depth is free
`timescale 1ns/1ps
module ovt_overlay_map_event_trace_tb_top
	import ovt_pkg::*;
;
	logic clock, sys_rst, regWr, regRd, irq, cpuReq, cpuWr, cpuReady, cpuHold, cpuSpecInt;
	logic tgtReq, tgtWr, tgtReady, auxTrigOut, intClk, intClkSel, tgtSeen, clkLast;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata;
	logic [ADDR_W-1:0] cpuAddr, tgtAddr;
	logic [DATA_W-1:0] cpuWdata, cpuRdata, tgtWdata, tgtRdata, q;
	logic [STAT_W-1:0] cpuStat;
	logic [AUX_W-1:0] auxPodIn;
	logic [55:0] e; // expected trace entry
	int n_fail, n_compared, trigCnt, clkTog, l0, l3, lf, n;
	ovt_attr_e at [5] = '{ATTR_TARGET, ATTR_RW, ATTR_TARGET, ATTR_ILLEGAL, ATTR_RO};

	ovt_overlay_map_event_trace u_ovt_overlay_map_event_trace (.clock(clock), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .irq(irq), .cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuWr(cpuWr),
		.cpuWdata(cpuWdata), .cpuStat(cpuStat), .cpuRdata(cpuRdata), .cpuReady(cpuReady),
		.cpuHold(cpuHold), .cpuSpecInt(cpuSpecInt), .tgtReq(tgtReq), .tgtAddr(tgtAddr),
		.tgtWr(tgtWr), .tgtWdata(tgtWdata), .tgtRdata(tgtRdata), .tgtReady(tgtReady),
		.auxPodIn(auxPodIn), .auxTrigOut(auxTrigOut), .intClk(intClk), .intClkSel(intClkSel));
	ovt_tgt_model u_ovt_tgt_model (.clock(clock), .sys_rst(sys_rst), .tgtReq(tgtReq),
		.tgtAddr(tgtAddr), .tgtWr(tgtWr), .tgtWdata(tgtWdata), .waitCnt(4'h3),
		.tgtRdata(tgtRdata), .tgtReady(tgtReady));

	always #5 clock = ~clock;
	// watchers: target use, trigger pulses, internal clock toggles
	always @(posedge clock) begin
		if (tgtReq === 1'b1) tgtSeen = 1'b1;
		if (auxTrigOut === 1'b1) trigCnt++;
		if (intClk !== clkLast) clkTog++;
		clkLast = intClk;
	end

	task automatic close_out();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one-cycle strobes, a free cycle between calls
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] x);
		@(posedge clock);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd <= 1'b0;
		@(posedge clock);
		chk(nm, regRdata & m, x);
	endtask
	// request held until ready, dropped in the ready cycle; c counts edges
	task automatic cpu(input logic [19:0] a, input logic w, input logic [15:0] d,
			output logic [15:0] r, output int c);
		c = 0;
		tgtSeen = 1'b0;
		@(posedge clock);
		cpuReq <= 1'b1;
		cpuAddr <= a;
		cpuWr <= w;
		cpuWdata <= d;
		cpuStat <= 3'h5;
		do begin
			@(posedge clock);
			c++;
		end while (cpuReady !== 1'b1 && c < 100);
		r = cpuRdata;
		cpuReq <= 1'b0;
		if (c >= 100) begin
			n_fail++;
			close_out();
		end
	endtask

	initial begin
		clock = 0;
		sys_rst = 1;
		{regWr, regRd, cpuReq, cpuWr, regAddr, regWdata, cpuAddr, cpuWdata, cpuStat} = '0;
		auxPodIn = 16'hbeef;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		chk("hold", {31'h0, cpuHold}, 1);
		rdc("stat", REG_STAT, 32'hffffffff, 0);
		rdc("unmapped", 8'hfc, 32'hffffffff, 0);
		// units 1..4 take every attribute kind
		for (int i = 1; i < 5; i++) begin
			wr(REG_MAPIDX, i);
			wr(REG_MAPATTR, 32'(at[i]));
		end
		wr(REG_IMASK, 32'hf);
		wr(REG_CTRL, 32'h1);
		cpu(20'h00800, 1, 16'h1234, q, n);
		chk("ovl wr tgt", {31'h0, tgtSeen}, 0);
		cpu(20'h00800, 0, 0, q, l0);
		chk("ovl rd", {16'h0, q}, 32'h1234);
		chk("ovl rd tgt", {31'h0, tgtSeen}, 0);
		// first word of the next unit belongs to the target
		cpu(20'h01000, 1, 16'ha5a5, q, n);
		chk("tgt wr", {31'h0, tgtSeen}, 1);
		cpu(20'h01000, 0, 0, q, n);
		chk("tgt rd", {16'h0, q}, 32'ha5a5);
		wr(REG_CTRL, 32'h31);
		cpu(20'h00800, 0, 0, q, l3);
		wr(REG_CTRL, 32'hf1);
		cpu(20'h00800, 0, 0, q, lf);
		chk("ws3", l3 - l0, 3);
		chk("ws15", lf - l0, 15);
		wr(REG_CTRL, 32'h1);
		// trace read back while still running
		rdc("trcnt", REG_TRCNT, 32'hffffffff, 6);
		wr(REG_TRIDX, 0);
		for (int i = 0; i < 2; i++) begin
			e = {20'h00800, 16'h1234, 3'h5, i == 0, 16'hbeef};
			rdc("trlo", REG_TRLO, 32'hffffffff, e[31:0]);
			rdc("trhi", REG_TRHI, 32'hffffffff, {8'h0, e[55:32]});
		end
		// break on address plus aux pattern, then trigger and jump
		auxPodIn <= 16'h1234;
		wr(REG_EVADDR, 32'h01000);
		wr(REG_EVAMSK, 32'hfffff);
		wr(REG_EVAUX, 32'hffffbeef);
		wr(REG_EVACT, 32'h115);
		cpu(20'h01000, 0, 0, q, n);
		rdc("no brk", REG_STAT, 32'h1, 1);
		auxPodIn <= 16'hbeef;
		rdc("settle", REG_STAT, 32'h1, 1);
		cpu(20'h01000, 0, 0, q, n);
		rdc("brk grp", REG_STAT, 32'h7, 32'h2);
		chk("trig", trigCnt, 1);
		rdc("brk ist", REG_ISTAT, 32'h4, 32'h4);
		chk("irq", {31'h0, irq}, 1);
		chk("brk hold", {31'h0, cpuHold}, 1);
		rdc("frozen", REG_TRCNT, 32'hffffffff, 8);
		wr(REG_ISTAT, 32'hf);
		rdc("ist clr", REG_ISTAT, 32'hf, 0);
		chk("irq clr", {31'h0, irq}, 0);
		// shutdown interrupt and counting, then operator stop
		wr(REG_EVACT, 32'h28);
		wr(REG_CTRL, 32'h1);
		cpu(20'h01000, 0, 0, q, n);
		rdc("sint", REG_STAT, 32'hffffffff, 32'h00010009);
		chk("sint pin", {31'h0, cpuSpecInt}, 1);
		wr(REG_CTRL, 32'h2);
		rdc("stop", REG_STAT, 32'hf, 0);
		chk("stop hold", {31'h0, cpuHold}, 1);
		rdc("stop ist", REG_ISTAT, 32'h1, 1);
		wr(REG_ISTAT, 32'hf);
		// violations: illegal read and read-only write
		wr(REG_EVACT, 0);
		wr(REG_CTRL, 32'h1);
		cpu(20'h01800, 0, 16'h5a5a, q, n);
		chk("ill data", {16'h0, q}, 0);
		rdc("ill ist", REG_ISTAT, 32'h3, 32'h3);
		chk("ill hold", {31'h0, cpuHold}, 1);
		wr(REG_ISTAT, 32'hf);
		wr(REG_CTRL, 32'h1);
		wr(REG_OVLADR, 32'h2000);
		wr(REG_OVLDAT, 32'h4242);
		cpu(20'h02000, 1, 16'h1111, q, n);
		rdc("ro ist", REG_ISTAT, 32'h3, 32'h3);
		rdc("ro kept", REG_OVLDAT, 32'hffff, 32'h4242);
		wr(REG_IMASK, 0);
		rdc("masked", REG_IMASK, 32'hf, 0);
		chk("irq mask", {31'h0, irq}, 0);
		wr(REG_IMASK, 32'hf);
		wr(REG_ISTAT, 32'hf);
		// null target: target units served from overlay, internal clock runs
		clkTog = 0;
		wr(REG_CTRL, 32'h5);
		cpu(20'h01002, 1, 16'h7777, q, n);
		cpu(20'h01002, 0, 0, q, n);
		chk("null rd", {16'h0, q}, 32'h7777);
		chk("null tgt", {31'h0, tgtSeen}, 0);
		chk("clk sel", {31'h0, intClkSel}, 1);
		chk("clk run", {31'h0, clkTog > 2}, 1);
		close_out();
	end
endmodule
